// ---- pkg/cq_pkg.sv ----
// constants shared by both ends of the queued-command link
`default_nettype none
package cq_pkg;
    // ==========================================
    // command indices
    localparam logic [5:0] IDX_STATUS = 6'h0D; // status poll
    localparam logic [5:0] IDX_SWITCH = 6'h06; // config byte write
    localparam logic [5:0] IDX_RDBYTE = 6'h08; // config byte read
    localparam logic [5:0] IDX_PARAM  = 6'h2C; // task parameters
    localparam logic [5:0] IDX_ADDR   = 6'h2D; // task address
    localparam logic [5:0] IDX_EXRD   = 6'h2E; // execute read task
    localparam logic [5:0] IDX_EXWR   = 6'h2F; // execute write task
    localparam logic [5:0] IDX_TMGMT  = 6'h30; // task management
    // ==========================================
    // argument field positions
    localparam int ARG_RELIABLE = 31;  // reliable write
    localparam int ARG_DIR      = 30;  // 1 read, 0 write
    localparam int ARG_TAG      = 29;  // tag request
    localparam int ARG_CTX_HI   = 28;  // context id msb
    localparam int ARG_CTX_LO   = 25;  // context id lsb
    localparam int ARG_FORCED   = 24;  // forced programming
    localparam int ARG_PRIO     = 23;  // high priority
    localparam int ARG_ID_HI    = 20;  // task id msb
    localparam int ARG_ID_LO    = 16;  // task id lsb
    localparam int ARG_BLK_HI   = 15;  // block count msb
    localparam int ARG_QSEL     = 15;  // queue status select
    localparam int ARG_PRI_INT  = 0;   // priority interrupt flag
    localparam int ARG_OP_HI    = 3;   // task mgmt operation msb
    localparam int ARG_IDX_HI   = 23;  // switch byte index msb
    localparam int ARG_IDX_LO   = 16;  // switch byte index lsb
    localparam int ARG_VAL_HI   = 15;  // switch value msb
    localparam int ARG_VAL_LO   = 8;   // switch value lsb
    localparam int ARG_RD_HI    = 8;   // read byte index msb
    // ==========================================
    // task management operations
    localparam logic [3:0] OP_DISCARD_ALL = 4'h1;
    localparam logic [3:0] OP_DISCARD_ONE = 4'h2;
    // ==========================================
    // configuration bytes
    localparam logic [8:0] OFS_ENABLE = 9'h00F; // queue_enable_ctrl
    localparam logic [8:0] OFS_DEPTH  = 9'h133; // queue_depth_info
    localparam logic [8:0] OFS_CAPAB  = 9'h134; // queue_capability
    localparam logic [7:0] CAPAB_VAL  = 8'h01;  // queuing supported
    localparam logic [4:0] DEPTH_N    = 5'h1F;  // depth minus one
    localparam logic       ENABLE_RST = 1'b0;   // queuing off at reset
    // ==========================================
    // framing
    localparam int CMD_BITS  = 38; // index + argument after start
    localparam int RSP_BITS  = 33; // error flag + argument
    localparam int HALF_DEF  = 8;  // mclk cycles per link half period
    localparam int WAIT_DEF  = 64; // link periods before timeout
endpackage : cq_pkg
`default_nettype wire

// ---- pkg/cq_link_if.sv ----
// the three wires between host and device
`default_nettype none
interface cq_link_if;
    logic linkClk; // host-made link clock
    logic cmdLine; // host to device, idle high
    logic rspLine; // device to host, idle high
    modport host (output linkClk, output cmdLine, input rspLine);
    modport dev  (input linkClk, input cmdLine, output rspLine);
endinterface : cq_link_if
`default_nettype wire

// ---- logic/cq_device.sv ----
// device end: command queue manager behind the serial link
//
// Overview of operation
// - parameter arg holds reliable, tag, context, forced bits
// - parameter bit 30 direction, recorded per task
// - priority bit 23, id 20:16, blocks 15:0
// - address command stores address, queues task
// - execute read/write only on ready task
// - op 2h discards the named task
// - op 1h ignores id, reserved bits ignored
// - status with select bit returns ready bitmap
// - capability byte reads 01h
// - depth byte reads 1Fh, ids 0..N
// - host discards queue before disabling
// - disabled queue acts like non-queuing device
// - bitmap bit i set when task i ready
// - bitmap bit clear when pending or unused
`default_nettype none
module cq_device #(
    parameter logic [4:0] DEPTH_N = cq_pkg::DEPTH_N // highest task id
) (
    input  wire logic        mclk,       // 20 MHz core clock
    input  wire logic        rstn,       // async reset, active low
    cq_link_if.dev           link,       // serial link to host
    output logic             execValid,  // one-cycle task launch
    output logic             execWrite,  // launched task is a write
    output logic [4:0]       execId,     // launched task id
    output logic [31:0]      execAddr,   // launched start block
    output logic [15:0]      execBlocks, // launched block count
    output logic [7:0]       execFlags,  // rel,tag,ctx[3:0],forced,prio
    output logic             queueOn,    // queuing enabled
    output logic [31:0]      readyMap    // task readiness bitmap
);
    // ==========================================
    // pin synchronisers and link clock edge
    logic [1:0]  clkSync_r;   // link clock, two stages
    logic [1:0]  cmdSync_r;   // command line, two stages
    logic        clkPrev_r;   // last synced clock level
    logic        rise;        // link clock rising edge seen

    // sync pins into mclk
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            clkSync_r <= 2'h0;
            cmdSync_r <= 2'h3;
            clkPrev_r <= 1'b0;
        end else begin
            clkSync_r <= {clkSync_r[0], link.linkClk};
            cmdSync_r <= {cmdSync_r[0], link.cmdLine};
            clkPrev_r <= clkSync_r[1];
        end
    end
    assign rise = clkSync_r[1] & ~clkPrev_r;

    // ==========================================
    // command frame receiver
    logic [5:0]  rxCnt_r;     // 0 idle, else bits taken + 1
    logic [37:0] rxShift_r;   // index and argument
    logic        frameDone_r; // one-cycle frame complete
    logic [5:0]  txCnt_r;     // response bits left
    logic [5:0]  idx;         // received index
    logic [31:0] arg;         // received argument

    // shift command bits on link rising edges
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxCnt_r     <= 6'h00;
            rxShift_r   <= 38'h0;
            frameDone_r <= 1'b0;
        end else begin
            frameDone_r <= rise && rxCnt_r == 6'(cq_pkg::CMD_BITS);
            if (rise) begin
                if (rxCnt_r == 6'h00) begin
                    // start bit only while not answering
                    if (!cmdSync_r[1] && txCnt_r == 6'h00) begin
                        rxCnt_r <= 6'h01;
                    end
                end else begin
                    rxShift_r <= {rxShift_r[36:0], cmdSync_r[1]};
                    if (rxCnt_r == 6'(cq_pkg::CMD_BITS)) begin
                        rxCnt_r <= 6'h00;
                    end else begin
                        rxCnt_r <= rxCnt_r + 6'h01;
                    end
                end
            end
        end
    end
    assign idx = rxShift_r[37:32];
    assign arg = rxShift_r[31:0];

    // ==========================================
    // task state
    logic [31:0] taskValid_r;  // id in use
    logic [31:0] taskReady_r;  // id ready for execution
    logic [31:0] taskRead_r;   // recorded direction, 1 read
    logic [31:0] paramMem [32]; // parameter word per task
    logic [31:0] addrMem  [32]; // start block per task
    logic        pendValid_r;  // parameters waiting for address
    logic [31:0] pendArg_r;    // held parameter word
    logic        enable_r;     // queuing enabled

    // ==========================================
    // command decode
    logic        illegal;     // answer with error flag
    logic [31:0] rspArg;      // answer argument
    logic        doPend;      // latch parameters
    logic        doQueue;     // create task entry
    logic        doExec;      // launch ready task
    logic [31:0] clrMask;     // ids to free
    logic        doEnWr;      // enable byte written
    logic [4:0]  id;          // id field of argument
    logic [4:0]  pendId;      // id of held parameters

    assign id     = arg[cq_pkg::ARG_ID_HI:cq_pkg::ARG_ID_LO];
    assign pendId = pendArg_r[cq_pkg::ARG_ID_HI:cq_pkg::ARG_ID_LO];

    // classify the completed frame
    always_comb begin
        illegal = 1'b0;
        rspArg  = 32'h0;
        doPend  = 1'b0;
        doQueue = 1'b0;
        doExec  = 1'b0;
        clrMask = 32'h0;
        doEnWr  = 1'b0;
        case (idx)
            cq_pkg::IDX_STATUS: begin
                // bitmap only while queuing is on
                if (arg[cq_pkg::ARG_QSEL] && enable_r) begin
                    rspArg = taskReady_r;
                end else if (arg[cq_pkg::ARG_QSEL]) begin
                    illegal = 1'b1;
                end
            end
            cq_pkg::IDX_SWITCH: begin
                if (arg[cq_pkg::ARG_IDX_HI:cq_pkg::ARG_IDX_LO]
                        == cq_pkg::OFS_ENABLE[7:0]) begin
                    doEnWr = 1'b1;
                end else begin
                    illegal = 1'b1;
                end
            end
            cq_pkg::IDX_RDBYTE: begin
                case (arg[cq_pkg::ARG_RD_HI:0])
                    cq_pkg::OFS_ENABLE: rspArg = {31'h0, enable_r};
                    cq_pkg::OFS_DEPTH:  rspArg = {27'h0, DEPTH_N};
                    cq_pkg::OFS_CAPAB:  rspArg = {24'h0, cq_pkg::CAPAB_VAL};
                    default:            rspArg = 32'h0;
                endcase
            end
            cq_pkg::IDX_PARAM: begin
                // id beyond depth or still in use is refused
                if (!enable_r || id > DEPTH_N || taskValid_r[id]) begin
                    illegal = 1'b1;
                end else begin
                    doPend = 1'b1;
                end
            end
            cq_pkg::IDX_ADDR: begin
                if (!enable_r || !pendValid_r) begin
                    illegal = 1'b1;
                end else begin
                    doQueue = 1'b1;
                end
            end
            cq_pkg::IDX_EXRD, cq_pkg::IDX_EXWR: begin
                // direction must match the recorded one
                if (enable_r && taskReady_r[id]
                        && taskRead_r[id] == (idx == cq_pkg::IDX_EXRD)) begin
                    doExec      = 1'b1;
                    clrMask[id] = 1'b1;
                end else begin
                    illegal = 1'b1;
                end
            end
            cq_pkg::IDX_TMGMT: begin
                // only the op code and, for one task, the id count
                if (!enable_r) begin
                    illegal = 1'b1;
                end else if (arg[cq_pkg::ARG_OP_HI:0]
                        == cq_pkg::OP_DISCARD_ALL) begin
                    clrMask = 32'hFFFFFFFF;
                end else if (arg[cq_pkg::ARG_OP_HI:0]
                        == cq_pkg::OP_DISCARD_ONE) begin
                    clrMask[id] = 1'b1;
                end else begin
                    illegal = 1'b1;
                end
            end
            default: illegal = 1'b1;
        endcase
    end

    // ==========================================
    // enable byte and pending parameters
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enable_r    <= cq_pkg::ENABLE_RST;
            pendValid_r <= 1'b0;
            pendArg_r   <= 32'h0;
        end else if (frameDone_r) begin
            if (doEnWr) begin
                enable_r <= arg[cq_pkg::ARG_VAL_LO];
            end
            // any other frame breaks the parameter/address pair
            pendValid_r <= doPend;
            if (doPend) begin
                pendArg_r <= arg;
            end
        end
    end

    // ==========================================
    // per-task valid, ready and direction
    logic [31:0] setMask; // id queued this cycle
    assign setMask = (frameDone_r && doQueue) ? (32'h1 << pendId) : 32'h0;

    genvar t;
    generate
        for (t = 0; t < 32; t++) begin : g_task
            logic clr; // task freed this cycle
            assign clr = frameDone_r && clrMask[t];
            // ready rises one cycle after valid, clears in the same cycle as valid
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    taskValid_r[t] <= 1'b0;
                    taskReady_r[t] <= 1'b0;
                    taskRead_r[t]  <= 1'b0;
                end else begin
                    // a new entry wins over a clear in the same cycle
                    taskValid_r[t] <= (taskValid_r[t] & ~clr) | setMask[t];
                    taskReady_r[t] <= taskValid_r[t] & ~setMask[t] & ~clr;
                    if (setMask[t]) begin
                        taskRead_r[t] <= pendArg_r[cq_pkg::ARG_DIR];
                    end
                end
            end
        end
    endgenerate

    // task memories, written when queued
    always_ff @(posedge mclk) begin
        if (frameDone_r && doQueue) begin
            paramMem[pendId] <= pendArg_r;
            addrMem[pendId]  <= arg;
        end
    end

    // ==========================================
    // task launch toward the media side
    logic [31:0] ep; // parameters of launched task
    assign ep = paramMem[id];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            execValid  <= 1'b0;
            execWrite  <= 1'b0;
            execId     <= 5'h00;
            execAddr   <= 32'h0;
            execBlocks <= 16'h0;
            execFlags  <= 8'h00;
        end else begin
            execValid <= frameDone_r && doExec;
            if (frameDone_r && doExec) begin
                execWrite  <= idx == cq_pkg::IDX_EXWR;
                execId     <= id;
                execAddr   <= addrMem[id];
                execBlocks <= ep[cq_pkg::ARG_BLK_HI:0];
                execFlags  <= {ep[cq_pkg::ARG_RELIABLE], ep[cq_pkg::ARG_TAG],
                    ep[cq_pkg::ARG_CTX_HI:cq_pkg::ARG_CTX_LO],
                    ep[cq_pkg::ARG_FORCED], ep[cq_pkg::ARG_PRIO]};
            end
        end
    end
    assign queueOn  = enable_r;
    assign readyMap = taskReady_r;

    // ==========================================
    // response transmitter
    logic [33:0] txShift_r; // start, error flag, argument
    logic        rspPin_r;  // driven response level

    // one bit per link rising edge, idle high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            txCnt_r   <= 6'h00;
            txShift_r <= 34'h0;
            rspPin_r  <= 1'b1;
        end else if (frameDone_r) begin
            txCnt_r   <= 6'(cq_pkg::RSP_BITS + 1);
            txShift_r <= {1'b0, illegal, rspArg};
        end else if (rise) begin
            if (txCnt_r != 6'h00) begin
                rspPin_r  <= txShift_r[33];
                txShift_r <= {txShift_r[32:0], 1'b1};
                txCnt_r   <= txCnt_r - 6'h01;
            end else begin
                rspPin_r <= 1'b1;
            end
        end
    end
    assign link.rspLine = rspPin_r;
endmodule : cq_device
`default_nettype wire

// ---- logic/cq_host.sv ----
// host end: sends framed commands and collects answers
`default_nettype none
module cq_host #(
    parameter int HALF = cq_pkg::HALF_DEF, // mclk per link half period
    parameter int WAIT = cq_pkg::WAIT_DEF  // link periods to timeout
) (
    input  wire logic        mclk,       // 20 MHz core clock
    input  wire logic        rstn,       // async reset, active low
    cq_link_if.host          link,       // serial link to device
    input  wire logic        reqValid,   // command request
    input  wire logic [5:0]  reqIndex,   // command index
    input  wire logic [31:0] reqArg,     // command argument
    output logic             reqReady,   // idle, request taken
    output logic             rspValid,   // one-cycle answer
    output logic             rspIllegal, // device refused command
    output logic             rspTimeout, // no answer came
    output logic [31:0]      rspArg      // answer argument
);
    typedef enum {H_IDLE, H_SEND, H_WAIT, H_RECV} hstate_t;

    // ==========================================
    // link clock divider
    logic [7:0] divCnt_r; // cycles in this half period
    logic       clk_r;    // link clock level
    logic       fallEvt;  // clock about to fall

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= 8'h00;
            clk_r    <= 1'b0;
        end else if (divCnt_r == 8'(HALF - 1)) begin
            divCnt_r <= 8'h00;
            clk_r    <= ~clk_r;
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
        end
    end
    assign fallEvt = clk_r && divCnt_r == 8'(HALF - 1);
    assign link.linkClk = clk_r;

    // ==========================================
    // response line synchroniser
    logic [1:0] rspSync_r; // two stages
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rspSync_r <= 2'h3;
        end else begin
            rspSync_r <= {rspSync_r[0], link.rspLine};
        end
    end

    // ==========================================
    // command and answer sequencer
    hstate_t     state_r;  // sequencer state
    logic [38:0] shift_r;  // outgoing frame
    logic [7:0]  cnt_r;    // bits or periods counted
    logic [32:0] rx_r;     // incoming flag and argument
    logic        cmdPin_r; // driven command level
    logic [31:0] argOut;   // argument as sent

    // select bit forces the priority interrupt flag clear
    always_comb begin
        argOut = reqArg;
        if (reqIndex == cq_pkg::IDX_STATUS && reqArg[cq_pkg::ARG_QSEL]) begin
            argOut[cq_pkg::ARG_PRI_INT] = 1'b0;
        end
    end

    // bits change as the link clock falls
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= H_IDLE;
            shift_r    <= 39'h0;
            cnt_r      <= 8'h00;
            rx_r       <= 33'h0;
            cmdPin_r   <= 1'b1;
            reqReady   <= 1'b1;
            rspValid   <= 1'b0;
            rspIllegal <= 1'b0;
            rspTimeout <= 1'b0;
            rspArg     <= 32'h0;
        end else begin
            rspValid <= 1'b0;
            case (state_r)
                H_IDLE: begin
                    if (reqValid) begin
                        shift_r  <= {1'b0, reqIndex, argOut};
                        cnt_r    <= 8'h00;
                        reqReady <= 1'b0;
                        state_r  <= H_SEND;
                    end
                end
                H_SEND: begin
                    if (fallEvt) begin
                        if (cnt_r == 8'(cq_pkg::CMD_BITS + 1)) begin
                            cmdPin_r <= 1'b1;
                            cnt_r    <= 8'h00;
                            state_r  <= H_WAIT;
                        end else begin
                            cmdPin_r <= shift_r[38];
                            shift_r  <= {shift_r[37:0], 1'b1};
                            cnt_r    <= cnt_r + 8'h01;
                        end
                    end
                end
                H_WAIT: begin
                    if (fallEvt) begin
                        if (!rspSync_r[1]) begin
                            cnt_r   <= 8'h00;
                            state_r <= H_RECV;
                        end else if (cnt_r == 8'(WAIT - 1)) begin
                            rspValid   <= 1'b1;
                            rspTimeout <= 1'b1;
                            rspIllegal <= 1'b0;
                            rspArg     <= 32'h0;
                            reqReady   <= 1'b1;
                            state_r    <= H_IDLE;
                        end else begin
                            cnt_r <= cnt_r + 8'h01;
                        end
                    end
                end
                H_RECV: begin
                    if (fallEvt) begin
                        rx_r  <= {rx_r[31:0], rspSync_r[1]};
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r == 8'(cq_pkg::RSP_BITS - 1)) begin
                            rspValid   <= 1'b1;
                            rspTimeout <= 1'b0;
                            rspIllegal <= rx_r[31];
                            rspArg     <= {rx_r[30:0], rspSync_r[1]};
                            reqReady   <= 1'b1;
                            state_r    <= H_IDLE;
                        end
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end
    assign link.cmdLine = cmdPin_r;
endmodule : cq_host
`default_nettype wire

// ---- testbench/cq_link_chk.sv ----
// checker on the three link wires between the two ends
`default_nettype none
module cq_link_chk (
    input wire logic mclk,    // core clock
    input wire logic rstn,    // async reset, active low
    input wire logic linkClk, // link clock from host
    input wire logic cmdLine, // command wire
    input wire logic rspLine  // response wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // link timing and framing
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    idle_at_rst_a: assert property ($rose(rstn) |-> cmdLine && rspLine &&
        !linkClk) else $error("link not idle after reset");
    clk_half_a: assert property ($changed(linkClk) |=> $stable(linkClk)[*6])
        else $error("link clock half period short");
    cmd_edge_a: assert property ($changed(cmdLine) |-> !linkClk)
        else $error("command bit moved while clock high");
    rsp_edge_a: assert property ($changed(rspLine) |-> linkClk)
        else $error("response bit moved while clock low");
    cmd_hold_a: assert property ($changed(cmdLine) |=> $stable(cmdLine)[*8])
        else $error("command bit too short");
    rsp_hold_a: assert property ($changed(rspLine) |=> $stable(rspLine)[*8])
        else $error("response bit too short");
    cmd_start_a: assert property ($fell(cmdLine) |-> rspLine)
        else $error("command started during response");
    rsp_start_a: assert property ($fell(rspLine) |-> cmdLine)
        else $error("response started during command");
    // main traffic seen
    cover property ($fell(cmdLine));
    cover property ($fell(rspLine));
    cover property ($rose(linkClk));
endmodule : cq_link_chk
`default_nettype wire

// ---- testbench/emmc_command_queue_manager_test.sv ----
// self-checking bench: host and device joined over the link
`default_nettype none
module emmc_command_queue_manager_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rstn, reqValid, reqReady, rspValid, rspIllegal;
    logic        execValid, execWrite, queueOn, rspTimeout;
    logic [5:0]  reqIndex;
    logic [4:0]  execId, id;
    logic [31:0] reqArg, rspArg, execAddr, readyMap, expMap, p, a;
    logic [15:0] execBlocks;
    logic [7:0]  execFlags;
    logic [61:0] gotExec; // last launched task
    int          failures, checks_done, k, launches;
    cq_link_if link ();
    cq_host #(.HALF(7), .WAIT(8)) i_cq_host (.mclk(mclk), .rstn(rstn),
        .link(link), .reqValid(reqValid), .reqIndex(reqIndex),
        .reqArg(reqArg), .reqReady(reqReady), .rspValid(rspValid),
        .rspIllegal(rspIllegal), .rspTimeout(rspTimeout), .rspArg(rspArg));
    cq_device i_cq_device (.mclk(mclk), .rstn(rstn), .link(link),
        .execValid(execValid), .execWrite(execWrite), .execId(execId),
        .execAddr(execAddr), .execBlocks(execBlocks),
        .execFlags(execFlags), .queueOn(queueOn), .readyMap(readyMap));
    cq_link_chk i_cq_link_chk (.mclk(mclk), .rstn(rstn),
        .linkClk(link.linkClk), .cmdLine(link.cmdLine),
        .rspLine(link.rspLine));
    // ==========================================
    // clock, launch capture, watchdog
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // capture every launch and count them
    always @(posedge mclk) if (execValid === 1'b1) begin
        gotExec  <= {execWrite, execId, execAddr, execBlocks, execFlags};
        launches <= launches + 1;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        failures++;
        results();
    end
    // ==========================================
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // one command; answer argument compared for every command
    task automatic cmd(input logic [5:0] i, input logic [31:0] g,
                       input logic ill, input logic [31:0] e);
        int n;
        @(negedge mclk);
        while (reqReady !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        reqIndex <= i;
        reqArg   <= g;
        reqValid <= 1'b1;
        @(posedge mclk);
        reqValid <= 1'b0;
        n = 0;
        do @(negedge mclk); while (rspValid !== 1'b1 && ++n < 5000);
        check({rspValid, rspTimeout, rspIllegal, rspArg},
              {2'h2, ill, e});
    endtask : cmd
    task automatic qtask(input logic [4:0] t);
        p = $urandom;
        a = $urandom;
        p[20:16] = t;
        cmd(6'h2C, p, 1'b0, 32'h0);
        cmd(6'h2D, a, 1'b0, 32'h0);
        expMap[t] = 1'b1;
    endtask : qtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // ==========================================
    // main sequence
    initial begin
        rstn = 1'b0;
        reqValid = 1'b0;
        reqIndex = 6'h00;
        reqArg = 32'h0;
        expMap = 32'h0;
        void'($urandom(7497));
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        cmd(6'h08, 32'h133, 1'b0, 32'h1F);
        cmd(6'h08, 32'h134, 1'b0, 32'h01);
        cmd(6'h08, 32'h00F, 1'b0, 32'h00);
        cmd(6'h2C, 32'h0, 1'b1, 32'h0);
        cmd(6'h0D, 32'h8000, 1'b1, 32'h0);
        cmd(6'h06, 32'h000F0100, 1'b0, 32'h0);
        check(queueOn, 1'b1);
        cmd(6'h2D, 32'h0, 1'b1, 32'h0);
        for (k = 0; k < 3; k++) begin
            id = 5'($urandom);
            qtask(id);
            cmd(6'h0D, 32'h8001, 1'b0, expMap);
            cmd(p[30] ? 6'h2F : 6'h2E, {11'h0, id, 16'h0}, 1'b1, 32'h0);
            cmd(p[30] ? 6'h2E : 6'h2F, {11'h0, id, 16'h0}, 1'b0, 32'h0);
            check(gotExec, {~p[30], id, a, p[15:0], p[31], p[29:23]});
            check(launches, k + 1);
            expMap[id] = 1'b0;
            cmd(6'h0D, 32'h8000, 1'b0, expMap);
        end
        qtask(5'h03);
        qtask(5'h09);
        cmd(6'h0D, 32'h0, 1'b0, 32'h0);
        cmd(6'h30, 32'hFFE9FFF2, 1'b0, 32'h0);
        expMap[9] = 1'b0;
        cmd(6'h0D, 32'h8000, 1'b0, expMap);
        cmd(6'h2E, 32'h00090000, 1'b1, 32'h0);
        cmd(6'h30, 32'hFFE3FFF1, 1'b0, 32'h0);
        cmd(6'h0D, 32'h8000, 1'b0, 32'h0);
        cmd(6'h06, 32'h000F0000, 1'b0, 32'h0);
        cmd(6'h2C, 32'h0, 1'b1, 32'h0);
        check(queueOn, 1'b0);
        results();
    end
endmodule : emmc_command_queue_manager_test
`default_nettype wire
